//--- dv/serial_flags_sva.sv
// Port-level assertions for the serial unit event flag block
`timescale 1ns/1ps
`include "serial_flags_consts.svh"

module serial_flags_sva (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Events and status
  input wire logic        word_done_pulse,
  input wire logic        tx_dma_one_page_pulse,
  input wire logic        rx_dma_two_page_pulse,
  input wire logic        unit_soft_reset,
  input wire logic        irq
);
  import serial_flags_pkg::*;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence access_wait; psel && penable && !pready; endsequence
  sequence rd_flags; pready && !pwrite && paddr == {20'h0, `EVENT_FLAGS_ADDR}; endsequence
  chk_ready_wait: assert property (access_wait |=> pready) else $error("ready late");
  chk_ready_single: assert property (pready |=> !pready) else $error("ready held");
  chk_err_upper: assert property (pready && paddr[31:12] != 20'h0 |-> pslverr) else $error("no error");
  chk_err_qualified: assert property (pslverr |-> pready) else $error("stray error");
  chk_reserved_zero: assert property (rd_flags |-> (prdata & 32'hffff78f8) == 32'h0)
    else $error("reserved set");
  chk_done_irq: assert property (word_done_pulse |=> irq) else $error("no irq");
  chk_dma_irq: assert property (tx_dma_one_page_pulse || rx_dma_two_page_pulse |=> irq)
    else $error("no irq");
  // Soft reset excluded: its effect on flags is left open
  chk_irq_sticky: assert property (irq && !psel && !unit_soft_reset |=> irq) else $error("irq lost");
  chk_reset_release: assert property ($rose(presetn) |-> !irq && unit_soft_reset) else $error("bad reset");
  chk_soft_write: assert property (pready && pwrite && !pslverr && paddr == {20'h0, `CONTROL_ADDR}
    |-> unit_soft_reset == pwdata[15]) else $error("control lost");
endmodule : serial_flags_sva

//--- dv/serial_unit_interrupt_flags_tb.sv
// Self-checking bench for the serial unit event flag block
`timescale 1ns/1ps
`include "serial_flags_consts.svh"

module serial_unit_interrupt_flags_tb;
  import serial_flags_pkg::*;
  localparam logic [31:0] FLG = {20'h0, `EVENT_FLAGS_ADDR};
  localparam logic [31:0] SLV = {20'h0, `SLOT_VALID_ADDR};
  localparam logic [31:0] CTL = {20'h0, `CONTROL_ADDR};
  localparam logic [31:0] LVL = {20'h0, `TRIGGER_LEVEL_ADDR};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        tx_halt, rx_halt, unit_soft_reset, irq;
  logic [31:0] paddr, pwdata, prdata, q;
  logic [4:0]  ev;
  logic [1:0]  cond;
  logic [3:0]  tx_fifo_count, rx_fifo_count;
  half_word_t  rx_slot_fill;
  int          fails, n_checks;
  int          bits [5] = '{15, 10, 9, 2, 1};

  // Byte lanes tied on: every register is one full half word
  serial_unit_interrupt_flags #(.FIFO_DEPTH_BITS(4)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'h3), .prdata, .pready, .pslverr,
    .word_done_pulse(ev[0]), .tx_dma_two_page_pulse(ev[1]), .tx_dma_one_page_pulse(ev[2]),
    .rx_dma_two_page_pulse(ev[3]), .rx_dma_one_page_pulse(ev[4]), .tx_fifo_empty(cond[1]),
    .rx_fifo_full(cond[0]), .tx_fifo_count, .rx_fifo_count, .rx_slot_fill, .tx_halt, .rx_halt,
    .unit_soft_reset, .irq);

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Answer taken at the rising edge where pready is seen high, then released
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic pulse(input logic [4:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= 5'h0;
  endtask : pulse
  task automatic wrap_up();
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    wrap_up();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ev, cond} = '0;
    {tx_fifo_count, rx_fifo_count, rx_slot_fill} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(FLG, 32'h0);
    rd(SLV, 32'h0);
    rd(CTL, 32'h8000);
    apb(1'b1, CTL, 32'h0);
    for (int i = 0; i < 5; i++) begin
      pulse(5'h1 << i);
      apb(1'b1, FLG, 32'h0);
      rd(FLG, 32'h1 << bits[i]);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, FLG, 32'h1 << bits[i]);
      rd(FLG, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    pulse(5'h11);
    apb(1'b1, FLG, 32'h8000);
    rd(FLG, 32'h2);
    apb(1'b1, FLG, 32'h2);
    apb(1'b1, LVL, 32'h0302);
    for (int d = 0; d < 2; d++) begin
      pulse(5'h0);
      cond[d] <= 1'b1;
      pulse(5'h0);
      cond[d] <= 1'b0;
      rd(FLG, d ? 32'h100 : 32'h1);
      apb(1'b1, FLG, 32'h101);
      apb(1'b1, CTL, d ? 32'h1000 : 32'h10);
      cond[d] <= 1'b1;
      {tx_fifo_count, rx_fifo_count} <= d ? 8'h20 : 8'h01;
      rd(FLG, 32'h0);
      chk({31'h0, d ? tx_halt : rx_halt}, 32'h0);
      {tx_fifo_count, rx_fifo_count} <= d ? 8'h30 : 8'h02;
      rd(FLG, d ? 32'h100 : 32'h1);
      chk({31'h0, d ? tx_halt : rx_halt}, 32'h1);
      {cond, tx_fifo_count, rx_fifo_count} <= '0;
      apb(1'b1, CTL, 32'h0);
      apb(1'b1, FLG, 32'h101);
    end
    rx_slot_fill <= 16'h00ff;
    pulse(5'h0);
    rx_slot_fill <= 16'h0;
    rd(SLV, 32'hff);
    apb(1'b1, SLV, 32'hf0);
    rd(SLV, 32'hf0);
    apb(1'b1, CTL, 32'h8000);
    rd(SLV, 32'h0);
    apb(1'b0, 32'h6fc, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 32'h0f0001b2, 32'h8000);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, CTL, 32'h0);
    pulse(5'h1);
    presetn <= 1'b0;
    pulse(5'h0);
    presetn <= 1'b1;
    rd(FLG, 32'h0);
    wrap_up();
  end
endmodule : serial_unit_interrupt_flags_tb

bind serial_unit_interrupt_flags serial_flags_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .word_done_pulse, .tx_dma_one_page_pulse, .rx_dma_two_page_pulse,
  .unit_soft_reset, .irq);

//--- rtl/serial_unit_interrupt_flags.sv
// Event flag, slot valid and control registers of the serial unit, reached over APB
`timescale 1ns/1ps
`include "serial_flags_consts.svh"

// Notes on behaviour
// - Word transmit or receive completion sets flag bit 15.
// - Transmit DMA beyond two pages sets flag bit 10.
// - Transmit DMA beyond one page sets flag bit 9.
// - Trigger select off: transmit FIFO empty sets bit 8.
// - Trigger select on: transmit trigger level reached sets bit 8.
// - Receive DMA beyond two pages sets flag bit 2.
// - Receive DMA beyond one page sets flag bit 1.
// - Trigger select off: receive FIFO full sets bit 0.
// - Trigger select on: receive trigger level reached sets bit 0.
// - Flags stay set until software writes one to them.
// - Reserved bits 14:11 and 7:3 read zero; software writes zero.
// - Reset clears every flag.
// - Trigger select halts its direction when FIFO reaches trigger level.
// - Writing zero to a slot valid bit clears it.
// - Reset or soft reset clears all slot valid bits.
module serial_unit_interrupt_flags #(
  parameter int FIFO_DEPTH_BITS = 4
) (
  // Clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // APB slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [31:0]                     paddr,
  input  wire logic [31:0]                     pwdata,
  input  wire logic [3:0]                      pstrb,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Events from the serial core, one-cycle pulses
  input  wire logic                            word_done_pulse,
  input  wire logic                            tx_dma_two_page_pulse,
  input  wire logic                            tx_dma_one_page_pulse,
  input  wire logic                            rx_dma_two_page_pulse,
  input  wire logic                            rx_dma_one_page_pulse,
  // FIFO state from the serial core
  input  wire logic                            tx_fifo_empty,
  input  wire logic                            rx_fifo_full,
  input  wire logic [FIFO_DEPTH_BITS-1:0]      tx_fifo_count,
  input  wire logic [FIFO_DEPTH_BITS-1:0]      rx_fifo_count,
  input  wire serial_flags_pkg::half_word_t    rx_slot_fill,
  // Outputs to the serial core and system
  output logic                                 tx_halt,
  output logic                                 rx_halt,
  output logic                                 unit_soft_reset,
  output logic                                 irq
);
  import serial_flags_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  half_word_t     event_flags;
  half_word_t     next_event_flags;
  half_word_t     slot_valid;
  half_word_t     next_slot_valid;
  half_word_t     control;
  half_word_t     next_control;
  half_word_t     trigger_levels;
  half_word_t     next_trigger_levels;
  logic [31:0]    next_prdata;
  logic           next_pslverr;
  logic           access_done;
  logic           next_access_done;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic           setup_phase;
  logic           write_strobe;
  logic           addr_ok;
  logic           hit_flags;
  logic           hit_slots;
  logic           hit_control;
  logic           hit_levels;
  half_word_t     wdata_lanes;
  half_word_t     lane_mask;
  logic           tx_trigger_select;
  logic           rx_trigger_select;
  trigger_level_t tx_trigger_level;
  trigger_level_t rx_trigger_level;
  logic           tx_level_hit;
  logic           rx_level_hit;
  half_word_t     event_set;

  // One wait state: pready rises on the edge after the first access cycle
  assign setup_phase  = psel && !penable;
  assign addr_ok      = paddr[31:`ADDR_BITS] == '0 && paddr[1:0] == 2'b00;
  assign hit_flags    = addr_ok && paddr[`ADDR_BITS-1:0] == `EVENT_FLAGS_ADDR;
  assign hit_slots    = addr_ok && paddr[`ADDR_BITS-1:0] == `SLOT_VALID_ADDR;
  assign hit_control  = addr_ok && paddr[`ADDR_BITS-1:0] == `CONTROL_ADDR;
  assign hit_levels   = addr_ok && paddr[`ADDR_BITS-1:0] == `TRIGGER_LEVEL_ADDR;
  assign write_strobe = psel && penable && pwrite && !access_done;
  assign wdata_lanes  = pwdata[15:0];
  assign lane_mask    = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign pready       = access_done;

  assign tx_trigger_select = control[`CTL_TX_TRIGGER_BIT];
  assign rx_trigger_select = control[`CTL_RX_TRIGGER_BIT];
  assign tx_trigger_level  = trigger_levels[`TX_LEVEL_LSB +: 3];
  assign rx_trigger_level  = trigger_levels[`RX_LEVEL_LSB +: 3];
  assign unit_soft_reset   = control[`CTL_SOFT_RESET_BIT];

  // Trigger level widened to the count width and compared against the whole count
  assign tx_level_hit = tx_fifo_count >= FIFO_DEPTH_BITS'(tx_trigger_level);
  assign rx_level_hit = rx_fifo_count >= FIFO_DEPTH_BITS'(rx_trigger_level);

  // ----------------------------------------
  // Halt controls
  // ----------------------------------------
  assign tx_halt = tx_trigger_select && tx_level_hit;
  assign rx_halt = rx_trigger_select && rx_level_hit;

  // ----------------------------------------
  // Event sources
  // ----------------------------------------
  always_comb begin
    event_set = '0;
    event_set[`TRANSFER_DONE_BIT]   = word_done_pulse;
    event_set[`TX_DMA_TWO_PAGE_BIT] = tx_dma_two_page_pulse;
    event_set[`TX_DMA_ONE_PAGE_BIT] = tx_dma_one_page_pulse;
    event_set[`TX_FIFO_SPACE_BIT]   = tx_trigger_select ? tx_level_hit : tx_fifo_empty;
    event_set[`RX_DMA_TWO_PAGE_BIT] = rx_dma_two_page_pulse;
    event_set[`RX_DMA_ONE_PAGE_BIT] = rx_dma_one_page_pulse;
    event_set[`RX_FIFO_OVER_BIT]    = rx_trigger_select ? rx_level_hit : rx_fifo_full;
  end

  // ----------------------------------------
  // Register next values
  // ----------------------------------------
  always_comb begin
    next_event_flags    = event_flags;
    next_slot_valid     = slot_valid;
    next_control        = control;
    next_trigger_levels = trigger_levels;
    // Write one clears; a same-cycle event still wins
    if (write_strobe && hit_flags) begin
      next_event_flags = event_flags & ~(wdata_lanes & lane_mask);
    end
    next_event_flags = (next_event_flags | event_set) & `EVENT_FLAGS_MASK;
    // Write zero clears; the core's fill marks set again
    if (write_strobe && hit_slots) begin
      next_slot_valid = slot_valid & (wdata_lanes | ~lane_mask);
    end
    next_slot_valid = next_slot_valid | rx_slot_fill;
    if (write_strobe && hit_control) begin
      next_control = (control & ~(lane_mask & `CTL_WRITE_MASK))
                   | (wdata_lanes & lane_mask & `CTL_WRITE_MASK);
    end
    if (write_strobe && hit_levels) begin
      next_trigger_levels = (trigger_levels & ~lane_mask) | (wdata_lanes & lane_mask & 16'h0707);
    end
    // Soft reset wipes the slot marks, fills ignored while it stands
    if (next_control[`CTL_SOFT_RESET_BIT]) begin
      next_slot_valid = `SLOT_VALID_RESET;
    end
  end

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  always_comb begin
    next_access_done = psel && penable && !access_done;
    next_prdata      = prdata;
    next_pslverr     = 1'b0;
    if (psel && penable && !access_done) begin
      next_prdata = 32'h0000_0000;
      if (hit_flags) begin
        next_prdata = {16'h0000, event_flags & `EVENT_FLAGS_MASK};
      end else if (hit_slots) begin
        next_prdata = {16'h0000, slot_valid};
      end else if (hit_control) begin
        next_prdata = {16'h0000, control};
      end else if (hit_levels) begin
        next_prdata = {16'h0000, trigger_levels};
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_flags    <= `EVENT_FLAGS_RESET;
      slot_valid     <= `SLOT_VALID_RESET;
      control        <= `CTL_RESET;
      trigger_levels <= `TRIGGER_LEVEL_RESET;
      prdata         <= 32'h0000_0000;
      pslverr        <= 1'b0;
      access_done    <= 1'b0;
    end else begin
      event_flags    <= next_event_flags;
      slot_valid     <= next_slot_valid;
      control        <= next_control;
      trigger_levels <= next_trigger_levels;
      prdata         <= next_prdata;
      pslverr        <= next_pslverr;
      access_done    <= next_access_done;
    end
  end

  // ----------------------------------------
  // Interrupt request
  // ----------------------------------------
  assign irq = |event_flags;

  logic unused_bits;
  assign unused_bits = setup_phase;

endmodule : serial_unit_interrupt_flags

//--- shared/serial_flags_consts.svh
// Offsets, field positions and reset values of the serial flag block
`ifndef SERIAL_FLAGS_CONSTS_SVH
`define SERIAL_FLAGS_CONSTS_SVH

// ----------------------------------------
// Register indices (printed offsets not word aligned)
// ----------------------------------------
`define EVENT_FLAGS_INDEX      32'h0f0001b2
`define SLOT_VALID_INDEX       32'h0f0001b4
`define CONTROL_INDEX          32'h0f0001b0
`define TRIGGER_LEVEL_INDEX    32'h0f0001b6
`define ADDR_BITS              12
`define EVENT_FLAGS_ADDR       12'h6c8
`define SLOT_VALID_ADDR        12'h6d0
`define CONTROL_ADDR           12'h6c0
`define TRIGGER_LEVEL_ADDR     12'h6d8

// ----------------------------------------
// Event flag field positions
// ----------------------------------------
`define TRANSFER_DONE_BIT      15
`define TX_DMA_TWO_PAGE_BIT    10
`define TX_DMA_ONE_PAGE_BIT    9
`define TX_FIFO_SPACE_BIT      8
`define RX_DMA_TWO_PAGE_BIT    2
`define RX_DMA_ONE_PAGE_BIT    1
`define RX_FIFO_OVER_BIT       0
`define EVENT_FLAGS_MASK       16'h8707

// ----------------------------------------
// Control and trigger level register fields
// ----------------------------------------
`define CTL_SOFT_RESET_BIT     15
`define CTL_TX_TRIGGER_BIT     12
`define CTL_RX_TRIGGER_BIT     4
`define CTL_WRITE_MASK         16'h9010
`define CTL_RESET              16'h8000
`define TX_LEVEL_LSB           8
`define RX_LEVEL_LSB           0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EVENT_FLAGS_RESET      16'h0000
`define SLOT_VALID_RESET       16'h0000
`define TRIGGER_LEVEL_RESET    16'h0000

`endif

//--- shared/serial_flags_pkg.sv
// Types shared by the serial flag block
package serial_flags_pkg;
  typedef logic [15:0] half_word_t;
  typedef logic [2:0]  trigger_level_t;
endpackage : serial_flags_pkg
